// *** inc/fmds_consts.svh ***
// Offsets, field positions and reset values of the fault mask/status block
`ifndef FMDS_CONSTS_SVH
`define FMDS_CONSTS_SVH
`define FMDS_MASK_OFFSET     8'h1E
`define FMDS_STATUS_OFFSET   8'h1F
`define FMDS_MASK_RESET      5'h00
`define FMDS_MASK_BOOST_BIT  4
`define FMDS_MASK_OPEN_BIT   3
`define FMDS_MASK_GND_BIT    2
`define FMDS_MASK_OTW_BIT    1
`define FMDS_MASK_SHORT_BIT  0
`define FMDS_ST_REF_CURRENT_PIN_BIT     5
`define FMDS_ST_BUV_BIT      4
`define FMDS_ST_BOV_BIT      3
`define FMDS_ST_PUP_BIT      2
`define FMDS_ST_OTW_BIT      1
`define FMDS_ST_OT_BIT       0
`define FMDS_STATUS_RESET    6'h04
`endif

// *** inc/fmds_pkg.sv ***
// Types shared by the fault mask/status block
package fmds_pkg;
	typedef struct packed {
		logic ref_current_out_of_range;
		logic boost_undervoltage;
		logic boost_overvoltage;
		logic overtemp_warning;
		logic overtemp_shutdown;
		logic open_led;
		logic ground_short;
		logic shorted_led;
	} fmds_fault_s;
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fmds_reg_req_s;
endpackage : fmds_pkg

// *** src/fmds_sync.sv ***
// Two-flop synchroniser for a vector of fault levels
`timescale 1ns/1ns
module fmds_sync (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] async_in,
	output logic      [7:0] sync_out
);
	logic [7:0] stage1_q;
	logic [7:0] stage1_d;
	logic [7:0] sync_d;

	always_comb begin
		stage1_d = async_in;
		sync_d   = stage1_q;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_q <= 8'h00;
			sync_out <= 8'h00;
		end else begin
			stage1_q <= stage1_d;
			sync_out <= sync_d;
		end
	end
endmodule : fmds_sync

// *** src/fmds_core.sv ***
// Fault pin mask and diagnostic status registers
`timescale 1ns/1ns
`include "fmds_consts.svh"

// Function
// RL1: Mask bit 4 keeps boost under- and overvoltage off the fault pin.
// RL2: Mask bit 3 keeps open-LED faults off the fault pin.
// RL3: Mask bit 2 keeps short-to-ground faults off the fault pin.
// RL4: Mask bit 1 keeps the overtemperature warning off the fault pin.
// RL5: Mask bit 0 keeps shorted-LED faults off the fault pin.
// RL6: The five mask bits reset to zero and are read/write.
// RL7: Status bit 5 flags reference current out of range and halts all.
// RL8: Boost undervoltage disables the boost and sets status bit 4.
// RL9: Status bit 3 is set while the boost sits at its overvoltage limit.
// RL10: Status bit 2 resets to one and clears after the first status read.
// RL11: Status bit 1 is set while the die is above the warning limit.
// RL12: Overtemperature shuts the device down and sets status bit 0.
// RL13: Status flags reset to zero except bit 2 and are read-only.
// RL14: The fault pin is low while any unmasked fault is active; overtemperature shutdown and reference current out of range never drive it.
module fmds_core (
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire fmds_pkg::fmds_reg_req_s reg_req,
	input  wire fmds_pkg::fmds_fault_s   fault_in,
	output logic [7:0]                 rd_data,
	output logic                       fault_out_n,
	output logic                       boost_enable,
	output logic                       device_run
);
	fmds_pkg::fmds_fault_s flt;
	logic [4:0] mask_q;
	logic [4:0] mask_d;
	logic [5:0] status_q;
	logic [5:0] status_d;
	logic       buv_latch_q;
	logic       buv_latch_d;
	logic       ot_latch_q;
	logic       ot_latch_d;
	logic [7:0] rd_data_d;
	logic       fault_out_n_d;
	logic       boost_enable_d;
	logic       device_run_d;
	logic       mask_sel;
	logic       status_sel;

	fmds_sync u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in (fault_in),
		.sync_out (flt)
	);

	assign mask_sel   = reg_req.addr == `FMDS_MASK_OFFSET;
	assign status_sel = reg_req.addr == `FMDS_STATUS_OFFSET;

	always_comb begin
		mask_d = mask_q;
		if (reg_req.wr_en && mask_sel) begin
			mask_d = reg_req.wdata[4:0]; // see RL6
		end
	end

	always_comb begin
		buv_latch_d = buv_latch_q | flt.boost_undervoltage; // see RL8
		ot_latch_d  = ot_latch_q | flt.overtemp_shutdown;   // see RL12
		status_d    = status_q;
		status_d[`FMDS_ST_REF_CURRENT_PIN_BIT] = flt.ref_current_out_of_range; // see RL7
		status_d[`FMDS_ST_BUV_BIT]  = buv_latch_d;          // see RL8
		status_d[`FMDS_ST_BOV_BIT]  = flt.boost_overvoltage; // see RL9
		status_d[`FMDS_ST_OTW_BIT]  = flt.overtemp_warning; // see RL11
		status_d[`FMDS_ST_OT_BIT]   = ot_latch_d;           // see RL12
		if (reg_req.rd_en && status_sel) begin
			status_d[`FMDS_ST_PUP_BIT] = 1'b0; // see RL10
		end
	end

	always_comb begin
		rd_data_d = 8'h00;
		if (mask_sel) begin
			rd_data_d = {3'h0, mask_q}; // see RL6
		end else if (status_sel) begin
			rd_data_d = {2'h0, status_q}; // see RL13
		end
		fault_out_n_d = !( // see RL14
			(!mask_q[`FMDS_MASK_BOOST_BIT] &&
				(buv_latch_q || flt.boost_overvoltage)) || // see RL1
			(!mask_q[`FMDS_MASK_OPEN_BIT] && flt.open_led) || // see RL2
			(!mask_q[`FMDS_MASK_GND_BIT] && flt.ground_short) || // see RL3
			(!mask_q[`FMDS_MASK_OTW_BIT] && flt.overtemp_warning) || // see RL4
			(!mask_q[`FMDS_MASK_SHORT_BIT] && flt.shorted_led)); // see RL5
		device_run_d   = !flt.ref_current_out_of_range && !ot_latch_d; // see RL7
		boost_enable_d = device_run_d && !buv_latch_d; // see RL8
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_q       <= `FMDS_MASK_RESET;   // see RL6
			status_q     <= `FMDS_STATUS_RESET; // see RL13
			buv_latch_q  <= 1'b0;
			ot_latch_q   <= 1'b0;
			rd_data      <= 8'h00;
			fault_out_n  <= 1'b1;
			boost_enable <= 1'b0;
			device_run   <= 1'b0;
		end else begin
			mask_q       <= mask_d;
			status_q     <= status_d;
			buv_latch_q  <= buv_latch_d;
			ot_latch_q   <= ot_latch_d;
			rd_data      <= rd_data_d;
			fault_out_n  <= fault_out_n_d;
			boost_enable <= boost_enable_d;
			device_run   <= device_run_d;
		end
	end
endmodule : fmds_core

// *** test/fmds_core_asserts.sv ***
// Checker for the fault mask/status block
`timescale 1ns/1ns
module fmds_core_asserts (
	input wire logic                    core_clk,
	input wire logic                    reset_n,
	input wire fmds_pkg::fmds_reg_req_s reg_req,
	input wire fmds_pkg::fmds_fault_s   fault_in,
	input wire logic [7:0]              rd_data,
	input wire logic                    fault_out_n,
	input wire logic                    boost_enable,
	input wire logic                    device_run
);
	logic [7:0] f;
	logic [4:0] m_q;
	assign f = fault_in;
	always_ff @(posedge core_clk or negedge reset_n)
		if (!reset_n) m_q <= 5'h00;
		else if (reg_req.wr_en && reg_req.addr == 8'h1E) m_q <= reg_req.wdata[4:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_run; f[7] |-> ##3 !device_run; endproperty
	property p_buv; f[6] |-> ##3 !boost_enable; endproperty
	property p_ot; f[3] |-> ##3 !device_run; endproperty
	property p_ov; f[5] && !m_q[4] |-> ##3 !fault_out_n; endproperty
	property p_open; f[2] && !m_q[3] |-> ##3 !fault_out_n; endproperty
	property p_rdm; reg_req.addr == 8'h1E && !reg_req.wr_en
		|=> rd_data == {3'h0, m_q}; endproperty
	property p_rds; reg_req.addr == 8'h1F |=> rd_data[7:6] == 2'h0; endproperty
	property p_pup; reg_req.rd_en && reg_req.addr == 8'h1F
		##1 reg_req.addr == 8'h1F |=> !rd_data[2]; endproperty
	a_run: assert property (p_run) else $error("run");
	a_buv: assert property (p_buv) else $error("boost");
	a_ot: assert property (p_ot) else $error("ot");
	a_ov: assert property (p_ov) else $error("ov pin");
	a_open: assert property (p_open) else $error("open pin");
	a_rdm: assert property (p_rdm) else $error("mask");
	a_rds: assert property (p_rds) else $error("status");
	a_pup: assert property (p_pup) else $error("pup");
	c_pin: cover property (f[2] ##3 !fault_out_n);
	c_pup: cover property (reg_req.rd_en && reg_req.addr == 8'h1F);
	c_halt: cover property (!device_run && !boost_enable);
endmodule : fmds_core_asserts
bind fmds_core fmds_core_asserts fmds_core_asserts_inst (.*);

// *** test/fmds_host.sv ***
// Register host model for the request port
`timescale 1ns/1ns
module fmds_host (
	input wire logic               core_clk,
	input wire logic [7:0]         rd_data,
	output fmds_pkg::fmds_reg_req_s reg_req
);
	initial reg_req = '0;
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk) reg_req = {2'h2, a, d};
		@(negedge core_clk) reg_req = {2'h0, a, ~d};
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk) reg_req = {2'h1, a, ~reg_req.wdata};
		@(negedge core_clk) d = rd_data;
		reg_req.rd_en = 1'b0;
	endtask : rd
endmodule : fmds_host

// *** test/tb.sv ***
// Self-checking bench for the fault mask/status block
`timescale 1ns/1ns
module tb;
	logic                    core_clk = 0;
	logic                    reset_n = 0;
	fmds_pkg::fmds_reg_req_s reg_req;
	fmds_pkg::fmds_fault_s   fault_in = '0;
	logic [7:0]              rd_data;
	logic                    fault_out_n;
	logic                    boost_enable;
	logic                    device_run;
	logic [31:0]             x = 32'hE6269197;
	logic [7:0]              m;
	int                      err_total = 0;
	int                      cmp_count = 0;
	fmds_core fmds_core_inst (.*);
	fmds_host fmds_host_inst (.*);
	initial forever #10 core_clk = ~core_clk;
	initial #60000 tally_and_finish(1);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		xs = s ^ (s << 5);
	endfunction : xs
	task cmp(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		fmds_host_inst.rd(a, d);
		cmp(d, e);
	endtask : rd
	task tally_and_finish(input int e);
		err_total += e;
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (7) @(negedge core_clk);
		reset_n = 1;
		rd(8'h1F, 8'h04);
		fmds_host_inst.wr(8'h1F, 8'hFF);
		rd(8'h1F, 8'h00);
		rd(8'h1E, 8'h00);
		repeat (24) begin
			x = xs(x);
			m = x[15:8];
			fmds_host_inst.wr(8'h1E, m);
			rd(8'h1E, m & 8'h1F);
			fault_in = x[7:0] & 8'h37;
			repeat (5) @(negedge core_clk);
			cmp({7'h0, fault_out_n}, {7'h0, ~|(x[5:0] &
				~{m[4], m[1], 1'b1, m[3:2], m[0]})});
			rd(8'h1F, {4'h0, x[5], 1'b0, x[4], 1'b0});
			cmp({6'h0, boost_enable, device_run}, 8'h03);
			fault_in = '0;
			repeat (5) @(negedge core_clk);
		end
		fault_in = 8'hC8;
		repeat (5) @(negedge core_clk);
		cmp({6'h0, boost_enable, device_run}, 8'h00);
		rd(8'h1F, 8'h31);
		fault_in = '0;
		repeat (5) @(negedge core_clk);
		rd(8'h1F, 8'h11);
		tally_and_finish(0);
	end
endmodule : tb
